// ==== sat_pkg.sv ====
// Package of bus arbitration timing constants and types.
package sat_pkg;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 10;
  localparam int ARB_DELAY_NS     = 2200;
  localparam int CLEAR_DELAY_NS   = 800;
  localparam int FREE_DELAY_NS    = 800;
  localparam int CLEAR_TOTAL_NS   = 1200;
  localparam int SETTLE_DELAY_NS  = 400;
  // Least times round up, longest times round down.
  localparam int ARB_CYC    = (ARB_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FREE_CYC   = (FREE_DELAY_NS + CLK_PERIOD_NS - 1)
                              / CLK_PERIOD_NS;
  localparam int CLEAR_CYC  = CLEAR_DELAY_NS / CLK_PERIOD_NS;
  localparam int TOTAL_CYC  = CLEAR_TOTAL_NS / CLK_PERIOD_NS;
  localparam int SETTLE_CYC = (SETTLE_DELAY_NS + CLK_PERIOD_NS - 1)
                              / CLK_PERIOD_NS;
  localparam int CNT_W      = 9;

  // ---------------------------------------------------------------------------
  // Bus widths and states
  // ---------------------------------------------------------------------------
  localparam int DATA_W = 8;

  typedef enum logic [2:0] {
    SAT_IDLE,
    SAT_FREE_WAIT,
    SAT_ARB_WAIT,
    SAT_OWNED,
    SAT_RELEASE
  } sat_state_t;

  function automatic logic sat_odd_par(input logic [7:0] d);
    sat_odd_par = ~(^d);
  endfunction

endpackage

// ==== sat_bus_if.sv ====
// Interface carrying the shared arbitration bus between two participants.
`timescale 1ns/1ps
`default_nettype none
interface sat_bus_if;
  // Active-low bus levels are resolved here from each end's enables.
  logic [7:0] dev_db_o,  dev_db_oe,  hst_db_o,  hst_db_oe;
  logic       dev_dbp_o, dev_dbp_oe, hst_dbp_o, hst_dbp_oe;
  logic       dev_bsy_oe, dev_sel_oe, hst_bsy_oe, hst_sel_oe;
  logic [7:0] db_n;
  logic       dbp_n;
  logic       bsy_n;
  logic       sel_n;

  // Open collector: a line is low when any end enables a low drive.
  assign db_n  = ~((dev_db_oe & ~dev_db_o) | (hst_db_oe & ~hst_db_o));
  assign dbp_n = ~((dev_dbp_oe & ~dev_dbp_o) | (hst_dbp_oe & ~hst_dbp_o));
  assign bsy_n = ~(dev_bsy_oe | hst_bsy_oe);
  assign sel_n = ~(dev_sel_oe | hst_sel_oe);

  modport dev (
    output dev_db_o, dev_db_oe, dev_dbp_o, dev_dbp_oe, dev_bsy_oe, dev_sel_oe,
    input  db_n, dbp_n, bsy_n, sel_n
  );
  modport hst (
    output hst_db_o, hst_db_oe, hst_dbp_o, hst_dbp_oe, hst_bsy_oe, hst_sel_oe,
    input  db_n, dbp_n, bsy_n, sel_n
  );
endinterface
`default_nettype wire

// ==== sat_arb_end.sv ====
// Arbitration timing engine for one bus participant (shared by both ends).
`timescale 1ns/1ps
`default_nettype none
module sat_arb_end #(
  parameter logic [2:0] MY_ID = 3'h7
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             arb_req,
  input  wire logic             parity_check_en,
  input  wire logic             sel_done,
  input  wire logic [7:0]       db_n,
  input  wire logic             dbp_n,
  input  wire logic             bsy_n,
  input  wire logic             sel_n,
  output logic [7:0]            db_o,
  output logic [7:0]            db_oe,
  output logic                  dbp_o,
  output logic                  dbp_oe,
  output logic                  bsy_oe,
  output logic                  sel_oe,
  output logic                  arb_won,
  output logic                  arb_lost,
  output logic                  bus_free,
  output logic                  parity_err
);
  import sat_pkg::*;

  sat_state_t       state;
  logic [CNT_W-1:0] free_cnt;
  logic [CNT_W-1:0] cnt;
  logic [7:0]       my_bit;
  logic             free_now;
  logic             higher_seen;

  // ---------------------------------------------------------------------------
  // Bus observation
  // ---------------------------------------------------------------------------
  assign free_now = bsy_n & sel_n;
  assign my_bit   = 8'h01 << MY_ID;

  // Any asserted identifier above ours beats us.
  always_comb begin
    higher_seen = 1'b0;
    for (int i = 0; i < DATA_W; i++) begin
      if (i > int'(MY_ID) && !db_n[i]) begin
        higher_seen = 1'b1;
      end
    end
  end

  // Time since busy and select both went false; bus free after settle.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      free_cnt <= '0;
    end else if (!free_now) begin
      free_cnt <= '0;
    end else if (free_cnt != '1) begin
      free_cnt <= free_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_free <= 1'b0;
    end else begin
      bus_free <= free_now && (free_cnt >= CNT_W'(SETTLE_CYC - 1));
    end
  end

  // ---------------------------------------------------------------------------
  // Arbitration sequence
  // ---------------------------------------------------------------------------
  // Detection happens SETTLE_CYC after the bus clears, so dropping drive on
  // the next edge keeps well inside both the 800 ns and 1200 ns budgets and
  // needs no separate shortened window for slow detection.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state    <= SAT_IDLE;
      cnt      <= '0;
      bsy_oe   <= 1'b0;
      sel_oe   <= 1'b0;
      db_o     <= 8'hFF;
      db_oe    <= 8'h00;
      dbp_o    <= 1'b1;
      dbp_oe   <= 1'b0;
      arb_won  <= 1'b0;
      arb_lost <= 1'b0;
    end else begin
      arb_won  <= 1'b0;
      arb_lost <= 1'b0;
      case (state)
        SAT_IDLE: begin
          cnt <= '0;
          if (arb_req && bus_free) begin
            state <= SAT_FREE_WAIT;
          end
        end
        SAT_FREE_WAIT: begin
          if (!bus_free) begin
            state <= SAT_IDLE;
          end else if (cnt >= CNT_W'(FREE_CYC - 1)) begin
            state  <= SAT_ARB_WAIT;
            cnt    <= '0;
            bsy_oe <= 1'b1;
            db_o   <= ~my_bit;
            db_oe  <= my_bit;
            // Parity need not be valid here; it is not driven.
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        SAT_ARB_WAIT: begin
          if (!sel_n && !sel_oe) begin
            state    <= SAT_IDLE;
            bsy_oe   <= 1'b0;
            db_oe    <= 8'h00;
            arb_lost <= 1'b1;
          end else if (cnt >= CNT_W'(ARB_CYC - 1)) begin
            if (higher_seen) begin
              state    <= SAT_IDLE;
              bsy_oe   <= 1'b0;
              db_oe    <= 8'h00;
              arb_lost <= 1'b1;
            end else begin
              state   <= SAT_OWNED;
              sel_oe  <= 1'b1;
              arb_won <= 1'b1;
            end
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        SAT_OWNED: begin
          // Owner drives its byte with odd parity.
          dbp_o  <= sat_odd_par(~db_o) ? 1'b0 : 1'b1;
          dbp_oe <= 1'b1;
          if (sel_done) begin
            state <= SAT_RELEASE;
          end
        end
        SAT_RELEASE: begin
          state  <= SAT_IDLE;
          bsy_oe <= 1'b0;
          sel_oe <= 1'b0;
          db_oe  <= 8'h00;
          dbp_oe <= 1'b0;
        end
        default: begin
          state <= SAT_IDLE;
        end
      endcase
      // Bus free seen while driving: drop every line at once.
      // The registered flag lags our own busy by one edge, so the live
      // level must agree too, or arbitration would abort itself.
      if (bus_free && free_now && state != SAT_IDLE
          && state != SAT_FREE_WAIT) begin
        state  <= SAT_IDLE;
        bsy_oe <= 1'b0;
        sel_oe <= 1'b0;
        db_oe  <= 8'h00;
        dbp_oe <= 1'b0;
      end
    end
  end

  // Parity is checked only outside arbitration, when enabled.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      parity_err <= 1'b0;
    end else begin
      parity_err <= parity_check_en && state == SAT_OWNED && !bsy_n
                    && ((^(~db_n)) == (~dbp_n));
    end
  end
endmodule
`default_nettype wire

// ==== sat_dev_end.sv ====
// Device end and host end wrappers binding the engine to the interface.
`timescale 1ns/1ps
`default_nettype none
module sat_dev_end #(
  parameter logic [2:0] MY_ID = 3'h6
) (
  input  wire logic   clk,
  input  wire logic   sys_rst,
  sat_bus_if.dev      bus,
  input  wire logic   arb_req,
  input  wire logic   parity_check_en,
  input  wire logic   sel_done,
  output logic        arb_won,
  output logic        arb_lost,
  output logic        bus_free,
  output logic        parity_err
);
  import sat_pkg::*;
  sat_arb_end #(.MY_ID(MY_ID)) u_end (
    .clk(clk), .sys_rst(sys_rst), .arb_req(arb_req),
    .parity_check_en(parity_check_en), .sel_done(sel_done),
    .db_n(bus.db_n), .dbp_n(bus.dbp_n), .bsy_n(bus.bsy_n), .sel_n(bus.sel_n),
    .db_o(bus.dev_db_o), .db_oe(bus.dev_db_oe), .dbp_o(bus.dev_dbp_o),
    .dbp_oe(bus.dev_dbp_oe), .bsy_oe(bus.dev_bsy_oe),
    .sel_oe(bus.dev_sel_oe), .arb_won(arb_won), .arb_lost(arb_lost),
    .bus_free(bus_free), .parity_err(parity_err)
  );
endmodule

module sat_hst_end #(
  parameter logic [2:0] MY_ID = 3'h7
) (
  input  wire logic   clk,
  input  wire logic   sys_rst,
  sat_bus_if.hst      bus,
  input  wire logic   arb_req,
  input  wire logic   sel_done,
  output logic        arb_won,
  output logic        arb_lost,
  output logic        bus_free
);
  import sat_pkg::*;
  sat_arb_end #(.MY_ID(MY_ID)) u_end (
    .clk(clk), .sys_rst(sys_rst), .arb_req(arb_req),
    .parity_check_en(1'b0), .sel_done(sel_done),
    .db_n(bus.db_n), .dbp_n(bus.dbp_n), .bsy_n(bus.bsy_n), .sel_n(bus.sel_n),
    .db_o(bus.hst_db_o), .db_oe(bus.hst_db_oe), .dbp_o(bus.hst_dbp_o),
    .dbp_oe(bus.hst_dbp_oe), .bsy_oe(bus.hst_bsy_oe),
    .sel_oe(bus.hst_sel_oe), .arb_won(arb_won), .arb_lost(arb_lost),
    .bus_free(bus_free), .parity_err()
  );
endmodule
`default_nettype wire

// ==== sat_asserts.sv ====
// Checker of arbitration timing on the shared bus.
`timescale 1ns/1ps
`default_nettype none
module sat_asserts
  import sat_pkg::*;
(
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic [7:0] dev_db_o,
  input wire logic [7:0] dev_db_oe,
  input wire logic       dev_dbp_o,
  input wire logic       dev_dbp_oe,
  input wire logic       dev_bsy_oe,
  input wire logic       dev_sel_oe,
  input wire logic [7:0] hst_db_oe,
  input wire logic       hst_bsy_oe,
  input wire logic       hst_sel_oe,
  input wire logic [7:0] db_n,
  input wire logic       bsy_n,
  input wire logic       sel_n
);
  logic [9:0] idle_cnt;
  logic [9:0] dbsy_cnt;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ---------------------------------------------------------------------------
  // Counters
  // ---------------------------------------------------------------------------
  // Saturates so a long idle bus never looks freshly released.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) idle_cnt <= '0;
    else if (!(bsy_n && sel_n)) idle_cnt <= '0;
    else if (idle_cnt != 10'h3FF) idle_cnt <= idle_cnt + 10'h001;
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) dbsy_cnt <= '0;
    else dbsy_cnt <= dev_bsy_oe ? dbsy_cnt + 10'h001 : 10'h000;
  end
  sequence foreign_sel_s;
    $rose(hst_sel_oe) && $past(dev_bsy_oe);
  endsequence
  sequence dev_clear_s;
    !dev_bsy_oe && !dev_sel_oe && (dev_db_oe == 8'h00);
  endsequence
  odd_parity_a: assert property (dev_dbp_oe |-> ^{~dev_db_o, ~dev_dbp_o})
    else $error("device parity not odd");
  free_wait_a: assert property ($rose(dev_bsy_oe) |-> idle_cnt >= FREE_CYC)
    else $error("device busy too soon");
  host_wait_a: assert property ($rose(hst_bsy_oe) |-> idle_cnt >= FREE_CYC)
    else $error("host busy too soon");
  arb_delay_a: assert property ($rose(dev_sel_oe) |-> dbsy_cnt >= ARB_CYC - 2)
    else $error("device decided too early");
  sel_release_a: assert property (foreign_sel_s |-> ##[0:80] dev_clear_s)
    else $error("device held bus on foreign select");
  idle_release_a: assert property ((idle_cnt >= TOTAL_CYC) && bsy_n && sel_n
    |-> !dev_bsy_oe && !dev_sel_oe && (dev_db_oe == 8'h00)
        && (hst_db_oe == 8'h00)) else $error("bus not cleared");
  prio_win_a: assert property ($rose(dev_sel_oe) |-> $past(db_n[7]))
    else $error("device won over higher id");
  one_owner_a: assert property (!(dev_sel_oe && hst_sel_oe))
    else $error("two owners");
  own_bit_a: assert property (dev_bsy_oe && !dev_sel_oe |-> dev_db_oe == 8'h40)
    else $error("device id bit wrong");
endmodule
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench joining the device end and the host end.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e, m) begin checks_done++; if ((a) !== (e)) begin \
  fail_count++; $display("unexpected at %0t: %s", $time, m); end end
module tb;
  import sat_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic d_req = 1'b0;
  logic h_req = 1'b0;
  logic d_done = 1'b0;
  logic h_done = 1'b0;
  logic d_pchk = 1'b1;
  logic d_won, d_lost, d_free, d_perr, h_won, h_lost, h_free;
  logic dw, dl, hw, hl;
  int   fail_count = 0;
  int   checks_done = 0;
  int   cyc_cnt = 0;
  int   n;
  always #5 clk = ~clk;
  sat_bus_if bus ();
  sat_dev_end sat_dev_end_i (.clk(clk), .sys_rst(sys_rst), .bus(bus.dev),
    .arb_req(d_req), .parity_check_en(d_pchk), .sel_done(d_done),
    .arb_won(d_won), .arb_lost(d_lost), .bus_free(d_free),
    .parity_err(d_perr));
  sat_hst_end sat_hst_end_i (.clk(clk), .sys_rst(sys_rst), .bus(bus.hst),
    .arb_req(h_req), .sel_done(h_done), .arb_won(h_won),
    .arb_lost(h_lost), .bus_free(h_free));
  sat_asserts sat_asserts_i (.clk(clk), .sys_rst(sys_rst),
    .dev_db_o(bus.dev_db_o), .dev_db_oe(bus.dev_db_oe),
    .dev_dbp_o(bus.dev_dbp_o), .dev_dbp_oe(bus.dev_dbp_oe),
    .dev_bsy_oe(bus.dev_bsy_oe), .dev_sel_oe(bus.dev_sel_oe),
    .hst_db_oe(bus.hst_db_oe), .hst_bsy_oe(bus.hst_bsy_oe),
    .hst_sel_oe(bus.hst_sel_oe), .db_n(bus.db_n), .bsy_n(bus.bsy_n),
    .sel_n(bus.sel_n));
  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  task automatic wait_res();
    {dw, dl, hw, hl} = 4'h0;
    for (n = 0; n < 600 && !(dw || hw); n++) begin
      @(posedge clk);
      #1;
      {dw, dl, hw, hl} |= {d_won, d_lost, h_won, h_lost};
    end
    // A loss on foreign select may land one edge after the win.
    @(posedge clk);
    #1;
    dl |= d_lost;
  endtask
  task automatic end_own(input logic dev);
    @(posedge clk);
    if (dev) d_done <= 1'b1; else h_done <= 1'b1;
    @(posedge clk);
    {d_done, h_done} <= 2'b00;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic t_alone();
    @(posedge clk);
    d_req <= 1'b1;
    wait_res();
    d_req <= 1'b0;
    `CHK(dw, 1'b1, "device lost alone")
    `CHK(n >= FREE_CYC + ARB_CYC, 1'b1, "device won early")
    `CHK(bus.db_n[6], 1'b0, "id bit not on line 6")
    `CHK(^{~bus.db_n, ~bus.dbp_n}, 1'b1, "wire parity even")
    end_own(1'b1);
    repeat (30) @(posedge clk);
    #1;
    `CHK(d_free, 1'b0, "free too soon")
    repeat (15) @(posedge clk);
    #1;
    `CHK(d_free, 1'b1, "free not seen")
    $display("alone test done");
  endtask
  task automatic t_both();
    @(posedge clk);
    {d_req, h_req} <= 2'b11;
    repeat (150) @(posedge clk);
    #1;
    `CHK(bus.db_n, 8'h3F, "arbitration bits wrong")
    `CHK(d_perr, 1'b0, "parity flagged in arbitration")
    wait_res();
    {d_req, h_req} <= 2'b00;
    `CHK({hw, dl, dw}, 3'b110, "priority wrong")
    `CHK({bus.dev_db_oe, bus.dev_bsy_oe}, 9'h000, "loser holds bus")
    `CHK(^{~bus.db_n, ~bus.dbp_n}, 1'b1, "host parity even")
    end_own(1'b0);
    $display("both test done");
  endtask
  task automatic t_refused();
    repeat (60) @(posedge clk);
    h_req <= 1'b1;
    wait_res();
    h_req <= 1'b0;
    d_req <= 1'b1;
    repeat (100) @(posedge clk);
    #1;
    `CHK(bus.dev_bsy_oe, 1'b0, "busy on owned bus")
    end_own(1'b0);
    wait_res();
    d_req <= 1'b0;
    `CHK(dw, 1'b1, "held request not served")
    `CHK(n >= SETTLE_CYC + FREE_CYC + ARB_CYC - 5, 1'b1, "late win early")
    end_own(1'b1);
    $display("refused test done");
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 5000) begin
      fail_count++;
      print_verdict();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (60) @(posedge clk);
    t_alone();
    t_both();
    t_refused();
    print_verdict();
  end
endmodule
`default_nettype wire
